// >>> verilog/acir_regblk.sv
// Purpose: Channel enable/status, last-result and interrupt flag and
//          mask registers of a sixteen-channel converter controller.
// Assumes: Conversion engine, comparator, DMA counters and calibration
//          run on i_clk and report here by one-cycle pulses or levels.
// Notes:   Only the calibration-running level is treated as asynchronous.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "acir_regs.svh"

module acir_regblk
   import acir_pkg::*;
(
   input  wire logic                i_clk,       // 125 MHz clock.
   input  wire logic                i_rst,       // Async reset, high.
   input  wire logic                i_ce,        // Clock enable.
   input  wire logic [31:0]         i_addr,      // Register byte address.
   input  wire acir_pkg::acir_word_t i_wdata,    // Write data.
   input  wire logic                i_wr,        // Write strobe.
   input  wire logic                i_rd,        // Read strobe.
   output acir_pkg::acir_word_t     o_rdata,     // Read data, next cycle.
   input  wire logic                i_conv_done, // Conversion end pulse.
   input  wire acir_pkg::acir_chnum_t i_conv_ch, // Converted channel.
   input  wire acir_pkg::acir_data_t i_conv_data, // Converted value.
   input  wire logic                i_ovr_evt,   // General overrun pulse.
   input  wire logic                i_cmp_evt,   // Compare event pulse.
   input  wire logic                i_temp_evt,  // Temperature change pulse.
   input  wire logic                i_rcnt_zero, // Receive counter is zero.
   input  wire logic                i_rncnt_zero, // Next counter is zero.
   input  wire logic                i_rcnt_wr,   // Counter write pulse.
   input  wire logic                i_cal_busy,  // Calibration running.
   input  wire logic                i_cal_req,   // Calibration requested.
   input  wire acir_pkg::acir_chnum_t i_channel_selection,    // Channel selection.
   input  wire logic                i_cdr_rd,    // Selected result read.
   output acir_pkg::acir_chmask_t   o_ch_en,     // Channel/slot enables.
   output logic                     o_user_sequence_mode,      // User sequence mode.
   output logic                     o_irq        // Masked flag summary.
);
   import acir_pkg::*;

   typedef struct packed {
      acir_word_t  rdata;
      acir_data_t  last_result_field;
      acir_chnum_t lch;
      acir_chmask_t eoc;
      logic        result_available_flag;
      logic        general_overrun_flag;
      logic        compare_event_flag;
      logic        temperature_change_flag;
      logic        receive_end_flag;
      logic        rz_prev;
      logic        cal_seen;
      logic [2:0]  ctrl;
   } acir_st_t;

   acir_st_t   st;
   acir_st_t   next_st;
   acir_chmask_t ch_en;
   acir_word_t imask;
   acir_word_t irq_set;
   acir_word_t irq_clr;
   acir_chmask_t ch_set;
   acir_chmask_t ch_clr;
   acir_word_t isr;
   logic       cal_busy_s;
   logic       wr_ok;
   logic       rz_both;
   logic       cal_done;

   // Calibration busy comes from the analog side, so it is synchronised.
   acir_sync3 u_cal_sync (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_ce  (i_ce),
      .i_d   (i_cal_busy),
      .o_q   (cal_busy_s)
   );

   assign wr_ok = i_wr & ~st.ctrl[`ACIR_CTRL_WRITE_PROTECT_ENABLE];

   assign ch_set = (wr_ok && i_addr == `ACIR_OFF_CH_EN) ?
                   i_wdata[`ACIR_NCH-1:0] : `ACIR_ZERO16;
   assign ch_clr = (wr_ok && i_addr == `ACIR_OFF_CH_DIS) ?
                   i_wdata[`ACIR_NCH-1:0] : `ACIR_ZERO16;

   acir_setclr #(.W(`ACIR_NCH)) u_ch (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_ce   (i_ce),
      .i_set  (ch_set),
      .i_clr  (ch_clr),
      .o_bits (ch_en)
   );

   assign irq_set = (i_wr && i_addr == `ACIR_OFF_IRQ_EN) ?
                    (i_wdata & `ACIR_IRQ_VALID) : `ACIR_ZERO32;
   assign irq_clr = (i_wr && i_addr == `ACIR_OFF_IRQ_DIS) ?
                    (i_wdata & `ACIR_IRQ_VALID) : `ACIR_ZERO32;

   acir_setclr #(.W(`ACIR_DW)) u_msk (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_ce   (i_ce),
      .i_set  (irq_set),
      .i_clr  (irq_clr),
      .o_bits (imask)
   );

   assign rz_both  = i_rcnt_zero & i_rncnt_zero;
   assign cal_done = st.cal_seen & ~cal_busy_s;

   always_comb begin
      isr = `ACIR_ZERO32;
      isr[`ACIR_NCH-1:0]   = st.eoc & ch_en;
      isr[`ACIR_B_RESULT_AVAILABLE_FLAG]    = st.result_available_flag;
      isr[`ACIR_B_GENERAL_OVERRUN_FLAG]   = st.general_overrun_flag;
      isr[`ACIR_B_COMPARE_EVENT_FLAG]   = st.compare_event_flag;
      isr[`ACIR_B_RECEIVE_END_FLAG]   = st.receive_end_flag;
      isr[`ACIR_B_RECEIVE_BUFFER_FULL_FLAG]  = rz_both;
      isr[`ACIR_B_TEMPERATURE_CHANGE_FLAG] = st.temperature_change_flag;
      isr[`ACIR_B_CALIBRATION_DONE_FLAG]   = cal_done;
   end

   // Flag, result and read-data updates. Every flag but receive end and
   // calibration done lets a set in the same cycle as its clear win, so no event is lost.
   always_comb begin
      logic st_rd;
      st_rd = i_rd && i_addr == `ACIR_OFF_IRQ_STAT;
      next_st = st;
      next_st.rz_prev  = i_rcnt_zero;
      if (i_wr && i_addr == `ACIR_OFF_CTRL) begin
         next_st.ctrl = i_wdata[`ACIR_CTRL_MSB:0];
      end
      if (i_cdr_rd) begin
         next_st.eoc[i_channel_selection] = 1'b0;
      end
      if (i_rd && i_addr == `ACIR_OFF_LAST) begin
         next_st.result_available_flag = 1'b0;
      end
      if (st_rd) begin
         next_st.general_overrun_flag   = 1'b0;
         next_st.compare_event_flag   = 1'b0;
         next_st.temperature_change_flag = 1'b0;
      end
      if (i_rcnt_wr) begin
         next_st.receive_end_flag = 1'b0;
      end else if (i_rcnt_zero && !st.rz_prev) begin
         next_st.receive_end_flag = 1'b1;
      end
      if (i_conv_done) begin
         next_st.last_result_field = i_conv_data;
         next_st.lch   = i_conv_ch;
         next_st.result_available_flag  = 1'b1;
         if (ch_en[i_conv_ch]) begin
            next_st.eoc[i_conv_ch] = 1'b1;
         end
      end
      if (i_ovr_evt) begin
         next_st.general_overrun_flag = 1'b1;
      end
      if (i_cmp_evt) begin
         next_st.compare_event_flag = 1'b1;
      end
      if (i_temp_evt) begin
         next_st.temperature_change_flag = 1'b1;
      end
      if (i_cal_req) begin
         next_st.cal_seen = 1'b0;
      end else if (cal_busy_s) begin
         next_st.cal_seen = 1'b1;
      end
      // Read data is defined for every address; unmapped reads give zero.
      next_st.rdata = `ACIR_ZERO32;
      if (i_rd) begin
         case (i_addr)
            `ACIR_OFF_CH_STAT:  next_st.rdata = `ACIR_DW'(ch_en);
            `ACIR_OFF_LAST: begin
               next_st.rdata[`ACIR_LAST_RESULT_FIELD_MSB:0] = st.last_result_field;
               next_st.rdata[`ACIR_RESULT_CHANNEL_FIELD_LSB+3:`ACIR_RESULT_CHANNEL_FIELD_LSB] =
                  st.ctrl[`ACIR_CTRL_TAG] ? st.lch : `ACIR_ZERO4;
            end
            `ACIR_OFF_IRQ_MASK: next_st.rdata = imask;
            `ACIR_OFF_IRQ_STAT: next_st.rdata = isr;
            `ACIR_OFF_CTRL:     next_st.rdata = `ACIR_DW'(st.ctrl);
            default:            next_st.rdata = `ACIR_ZERO32;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_ch_en = ch_en;
   assign o_user_sequence_mode  = st.ctrl[`ACIR_CTRL_USER_SEQUENCE_MODE];
   assign o_rdata = st.rdata;
   // Masked summary of pending flags for the system interrupt line.
   assign o_irq   = |(isr & imask);
endmodule // acir_regblk
`default_nettype wire

// >>> include/acir_regs.svh
// Purpose: Offsets, field positions and masks of the converter
//          channel and interrupt register block.
// Assumes: Byte addresses on a 32-bit register port.
// Notes:   Definitions only.
`ifndef ACIR_REGS_SVH
`define ACIR_REGS_SVH

`define ACIR_AW            32
`define ACIR_OFF_CH_EN     32'h400b0014
`define ACIR_OFF_CH_DIS    32'h400b0018
`define ACIR_OFF_CH_STAT   32'h400b001c
`define ACIR_OFF_LAST      32'h400b0020
`define ACIR_OFF_IRQ_EN    32'h400b0024
`define ACIR_OFF_IRQ_DIS   32'h400b0028
`define ACIR_OFF_IRQ_MASK  32'h400b002c
`define ACIR_OFF_IRQ_STAT  32'h400b0030
`define ACIR_OFF_CTRL      32'h400b00f0
`define ACIR_NCH           16
`define ACIR_B_RESULT_AVAILABLE_FLAG        24
`define ACIR_B_GENERAL_OVERRUN_FLAG       25
`define ACIR_B_COMPARE_EVENT_FLAG       26
`define ACIR_B_RECEIVE_END_FLAG       27
`define ACIR_B_RECEIVE_BUFFER_FULL_FLAG      28
`define ACIR_B_TEMPERATURE_CHANGE_FLAG     30
`define ACIR_B_CALIBRATION_DONE_FLAG       31
`define ACIR_IRQ_VALID     32'hdf00ffff
`define ACIR_CTRL_WRITE_PROTECT_ENABLE     0
`define ACIR_CTRL_TAG      1
`define ACIR_CTRL_USER_SEQUENCE_MODE     2
`define ACIR_RESULT_CHANNEL_FIELD_LSB      24
`define ACIR_CTRL_MSB      2
`define ACIR_LAST_RESULT_FIELD_MSB     15
`define ACIR_DW            32
`define ACIR_ZERO32        32'h0000_0000
`define ACIR_ZERO16        16'h0000
`define ACIR_ZERO4         4'h0

`endif

// >>> include/acir_pkg.sv
// Purpose: Shared types of the converter channel and interrupt block.
// Assumes: Used together with acir_regs.svh.
// Notes:   Types only.
package acir_pkg;
   typedef logic [31:0] acir_word_t;
   typedef logic [15:0] acir_chmask_t;
   typedef logic [3:0]  acir_chnum_t;
   typedef logic [15:0] acir_data_t;
endpackage

// >>> verilog/acir_setclr.sv
// Purpose: Set/clear bit array for enable-style registers.
// Assumes: Set and clear are single-cycle write strobes.
// Notes:   Clear wins where a bit is both set and cleared in one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "acir_regs.svh"
module acir_setclr #(
   parameter int W = 32
) (
   input  wire logic         i_clk,   // Clock.
   input  wire logic         i_rst,   // Async reset, active high.
   input  wire logic         i_ce,    // Clock enable.
   input  wire logic [W-1:0] i_set,   // Bits to set.
   input  wire logic [W-1:0] i_clr,   // Bits to clear.
   output logic      [W-1:0] o_bits   // Held bits.
);
   typedef struct packed {
      logic [W-1:0] bits;
   } acir_sc_t;
   acir_sc_t st;
   acir_sc_t next_st;

   // Each bit is set by a one, cleared by a one, kept by a zero.
   always_comb begin
      next_st = st;
      next_st.bits = (st.bits | i_set) & ~i_clr;
   end

   // State register; reset leaves every bit clear.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_bits = st.bits;
endmodule // acir_setclr
`default_nettype wire

// >>> verilog/acir_sync3.sv
// Purpose: Three-stage synchroniser for an asynchronous level.
// Assumes: One level per instance.
// Notes:   The output changes only once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module acir_sync3 (
   input  wire logic i_clk,   // Clock.
   input  wire logic i_rst,   // Async reset, active high.
   input  wire logic i_ce,    // Clock enable.
   input  wire logic i_d,     // Asynchronous level.
   output logic      o_q      // Filtered synchronous level.
);
   typedef struct packed {
      logic [2:0] sh;
      logic       q;
   } acir_sy_t;
   acir_sy_t st;
   acir_sy_t next_st;

   // Stage one is read only by stage two; the filter sees two and three.
   always_comb begin
      next_st = st;
      next_st.sh = {st.sh[1:0], i_d};
      if (st.sh[2] == st.sh[1]) begin
         next_st.q = st.sh[2];
      end
   end

   // State register.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_q = st.q;
endmodule // acir_sync3
`default_nettype wire

// >>> verif/acir_regblk_asserts.sv
// Purpose: Port-level checks of the converter register block.
// Assumes: Clock enable may drop; strobes count only while it is high; write protect and mask are shadowed.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
`include "acir_regs.svh"
module acir_regblk_asserts
   import acir_pkg::*;
(
   input wire logic                  i_clk,   // Clock.
   input wire logic                  i_rst,   // Async reset.
   input wire logic                  i_ce,    // Clock enable.
   input wire logic [31:0]           i_addr,  // Address.
   input wire acir_pkg::acir_word_t  i_wdata, // Write data.
   input wire logic                  i_wr,    // Write strobe.
   input wire logic                  i_rd,    // Read strobe.
   input wire acir_pkg::acir_word_t  o_rdata, // Read data.
   input wire acir_pkg::acir_chmask_t o_ch_en, // Channel enables.
   input wire logic                  o_user_sequence_mode,  // Sequence mode.
   input wire logic                  o_irq    // Interrupt summary.
);
   logic       wp;   // Shadow of write protect.
   acir_word_t msk;  // Shadow of the interrupt mask.
   wire logic  wr_c = i_ce && i_wr;
   wire logic  rd_c = i_ce && i_rd;
   // The shadows let the checks know state that no port shows.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wp <= 1'b0;
         msk <= '0;
      end else if (wr_c) begin
         if (i_addr == `ACIR_OFF_CTRL) wp <= i_wdata[0];
         if (i_addr == `ACIR_OFF_IRQ_EN) msk <= msk | (i_wdata & `ACIR_IRQ_VALID);
         if (i_addr == `ACIR_OFF_IRQ_DIS) msk <= msk & ~i_wdata;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Read data lives one cycle, so a cycle after no read must be zero.
   property p_idle; i_ce && !i_rd |=> o_rdata == '0; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_chen; wr_c && i_addr == `ACIR_OFF_CH_EN && !wp |=>
      o_ch_en == ($past(o_ch_en) | $past(i_wdata[15:0])); endproperty
   a_chen: assert property (p_chen) else $error("enable wrong");
   property p_chdis; wr_c && i_addr == `ACIR_OFF_CH_DIS && !wp |=>
      o_ch_en == ($past(o_ch_en) & ~$past(i_wdata[15:0])); endproperty
   a_chdis: assert property (p_chdis) else $error("disable wrong");
   property p_wprot; wr_c && wp && (i_addr == `ACIR_OFF_CH_EN ||
      i_addr == `ACIR_OFF_CH_DIS) |=> $stable(o_ch_en); endproperty
   a_wprot: assert property (p_wprot) else $error("protect broken");
   property p_stat; rd_c && i_addr == `ACIR_OFF_CH_STAT |=>
      o_rdata == {16'h0000, $past(o_ch_en)}; endproperty
   a_stat: assert property (p_stat) else $error("status wrong");
   property p_user_sequence_mode; wr_c && i_addr == `ACIR_OFF_CTRL |=>
      o_user_sequence_mode == $past(i_wdata[2]); endproperty
   a_user_sequence_mode: assert property (p_user_sequence_mode) else $error("user_sequence_mode wrong");
   property p_mask; rd_c && i_addr == `ACIR_OFF_IRQ_MASK |=>
      o_rdata == $past(msk); endproperty
   a_mask: assert property (p_mask) else $error("mask wrong");
   property p_last; rd_c && i_addr == `ACIR_OFF_LAST |=>
      o_rdata[31:28] == 4'h0 && o_rdata[23:16] == 8'h00; endproperty
   a_last: assert property (p_last) else $error("last reserved");
   property p_irq; msk == '0 |-> !o_irq; endproperty
   a_irq: assert property (p_irq) else $error("irq unmasked");
endmodule // acir_regblk_asserts
bind acir_regblk acir_regblk_asserts u_chk (
   .i_clk   (i_clk),
   .i_rst   (i_rst),
   .i_ce    (i_ce),
   .i_addr  (i_addr),
   .i_wdata (i_wdata),
   .i_wr    (i_wr),
   .i_rd    (i_rd),
   .o_rdata (o_rdata),
   .o_ch_en (o_ch_en),
   .o_user_sequence_mode  (o_user_sequence_mode),
   .o_irq   (o_irq)
);
`default_nettype wire

// >>> verif/test_acir_regblk.sv
// Purpose: Self-checking bench for the converter register block.
// Assumes: Clock enable held high except for one write; reads are checked through a queue.
// Notes:   Expected words come from bit models kept here.
`timescale 1ns/100ps
`default_nettype none
`include "acir_regs.svh"
module test_acir_regblk;
   import acir_pkg::*;
   logic         i_clk, i_rst, i_ce, i_wr, i_rd, i_rcnt_zero, i_rncnt_zero;
   logic         i_conv_done, i_ovr_evt, i_cmp_evt, i_temp_evt, i_rcnt_wr;
   logic         i_cal_busy, i_cal_req, i_cdr_rd, o_user_sequence_mode, o_irq, rd_q;
   acir_word_t   i_addr, i_wdata, o_rdata, ch, msk, e;
   acir_chnum_t  i_conv_ch, i_channel_selection, c;
   acir_data_t   i_conv_data, d;
   acir_chmask_t o_ch_en;
   logic [6:0]   pv;
   acir_word_t   expq[$];
   int           error_cnt = 0;
   int           n_checks = 0;
   // One vector drives all event pulses so none is assigned twice.
   assign {i_cdr_rd, i_conv_done, i_cal_req, i_rcnt_wr, i_temp_evt,
           i_cmp_evt, i_ovr_evt} = pv;
   acir_regblk dut (
      .i_clk        (i_clk),
      .i_rst        (i_rst),
      .i_ce         (i_ce),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .o_rdata      (o_rdata),
      .i_conv_done  (i_conv_done),
      .i_conv_ch    (i_conv_ch),
      .i_conv_data  (i_conv_data),
      .i_ovr_evt    (i_ovr_evt),
      .i_cmp_evt    (i_cmp_evt),
      .i_temp_evt   (i_temp_evt),
      .i_rcnt_zero  (i_rcnt_zero),
      .i_rncnt_zero (i_rncnt_zero),
      .i_rcnt_wr    (i_rcnt_wr),
      .i_cal_busy   (i_cal_busy),
      .i_cal_req    (i_cal_req),
      .i_channel_selection       (i_channel_selection),
      .i_cdr_rd     (i_cdr_rd),
      .o_ch_en      (o_ch_en),
      .o_user_sequence_mode       (o_user_sequence_mode),
      .o_irq        (o_irq)
   );
   task automatic chk(input acir_word_t got, exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input acir_word_t a, x);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= x;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   // The expectation is queued before the strobe, so order always matches.
   task automatic rd(input acir_word_t a, x);
      expq.push_back(x);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   task automatic risr(input acir_word_t x);
      rd(`ACIR_OFF_IRQ_STAT, x);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge i_clk);
      pv <= m;
      @(posedge i_clk);
      pv <= '0;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Read data is valid only the cycle after the strobe; look mid-cycle.
   always @(posedge i_clk) rd_q <= i_rd;
   always @(negedge i_clk) begin
      if (rd_q && expq.size() > 0) chk(o_rdata, expq.pop_front());
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      {i_rst, i_ce} = 2'b11;
      {i_wr, i_rd, i_rcnt_zero, i_rncnt_zero, i_cal_busy} = '0;
      {i_addr, i_wdata, i_conv_ch, i_conv_data, i_channel_selection} = '0;
      pv = '0;
      e = $urandom(93425);
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(`ACIR_OFF_CH_STAT, '0);
      rd(`ACIR_OFF_IRQ_MASK, '0);
      risr('0);
      ch = '0;
      msk = '0;
      repeat (4) begin
         e = $urandom;
         wr(`ACIR_OFF_CH_EN, e);
         ch = (ch | e) & 32'h0000ffff;
         rd(`ACIR_OFF_CH_STAT, ch);
         e = $urandom;
         wr(`ACIR_OFF_CH_DIS, e);
         ch = ch & ~e;
         rd(`ACIR_OFF_CH_STAT, ch);
         e = $urandom;
         wr(`ACIR_OFF_IRQ_EN, e);
         msk = msk | (e & 32'hdf00ffff);
         rd(`ACIR_OFF_IRQ_MASK, msk);
         e = $urandom;
         wr(`ACIR_OFF_IRQ_DIS, e);
         msk = msk & ~e;
         rd(`ACIR_OFF_IRQ_MASK, msk);
      end
      wr(`ACIR_OFF_CH_STAT, 32'hffffffff);
      rd(32'h400b0034, '0);
      wr(`ACIR_OFF_CTRL, 32'h1);
      wr(`ACIR_OFF_CH_EN, 32'hffffffff);
      wr(`ACIR_OFF_CH_DIS, 32'hffffffff);
      rd(`ACIR_OFF_CH_STAT, ch);
      wr(`ACIR_OFF_CTRL, 32'h6);
      rd(`ACIR_OFF_CTRL, 32'h6);
      wr(`ACIR_OFF_CH_EN, 32'hffffffff);
      wr(`ACIR_OFF_IRQ_EN, 32'hffffffff);
      rd(`ACIR_OFF_IRQ_MASK, 32'hdf00ffff);
      {c, d} = 20'($urandom);
      @(posedge i_clk);
      i_conv_ch <= c;
      i_conv_data <= d;
      i_channel_selection <= c;
      pulse(7'h20);
      risr((32'h1 << c) | 32'h01000000);
      rd(`ACIR_OFF_LAST, {4'h0, c, 8'h00, d});
      risr(32'h1 << c);
      pulse(7'h40);
      risr('0);
      wr(`ACIR_OFF_CTRL, '0);
      wr(`ACIR_OFF_CH_DIS, 32'h1 << c);
      pulse(7'h20);
      risr(32'h01000000);
      rd(`ACIR_OFF_LAST, {16'h0000, d});
      // A write while the clock enable is low must leave every bit frozen.
      i_ce <= 1'b0;
      wr(`ACIR_OFF_CH_DIS, 32'hffffffff);
      i_ce <= 1'b1;
      rd(`ACIR_OFF_CH_STAT, 32'h0000ffff & ~(32'h1 << c));
      pulse(7'h07);
      risr(32'h46000000);
      risr('0);
      @(posedge i_clk);
      i_rcnt_zero <= 1'b1;
      i_rncnt_zero <= 1'b1;
      repeat (2) @(posedge i_clk);
      risr(32'h18000000);
      @(negedge i_clk);
      chk(32'(o_irq), 32'h1);
      pulse(7'h08);
      risr(32'h10000000);
      i_rncnt_zero <= 1'b0;
      repeat (2) @(posedge i_clk);
      risr('0);
      pulse(7'h10);
      i_cal_busy <= 1'b1;
      repeat (6) @(posedge i_clk);
      risr('0);
      i_cal_busy <= 1'b0;
      repeat (6) @(posedge i_clk);
      risr(32'h80000000);
      repeat (3) @(posedge i_clk);
      summarize();
   end
endmodule // test_acir_regblk
`default_nettype wire
